// >>> rtl/loop_maintenance_decoder.sv
// How it works
// - Maintenance input filtered over 20 ms before any counting.
// - Pulses counted by level changes, so either polarity works.
// - Valid count forces transceiver state and raises an interrupt.
// - Selected maintenance mode shown on a two-bit output.
// - Valid sequences act in every transceiver state, power-down too.
// - Test mode lasts 75 s, then back to normal operation.
// - Another six- or eight-pulse sequence during the test restarts the full timer.
// - Six pulses: quiet mode, transceiver reset, timer started.
// - Eight pulses: insertion loss, transceiver transparent, timer started.
// - Ten pulses: normal operation, transceiver reset, timer not started.
// - Other counts ignored, transceiver left alone.
// - Masked sources neither read back nor request an interrupt.
// - Reading the status word clears it.
// - Read clears events before the request; later ones stay pending.
// - After the read, next unmasked pending event requests again.
// - Mask change after second request exposes collected events.
`timescale 1ns/1ns
module loop_maintenance_decoder
    import maint_pkg::*;
#(
    parameter int FILTER_LEN = FILTER_CYCLES,
    parameter int IDLE_LEN = IDLE_CYCLES,
    parameter logic [63:0] TEST_LEN = TEST_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic maint_pulse_in,
    input wire logic u_cmd_ind_change_src,
    input wire logic embedded_ops_rx_src,
    input wire logic maint_bit4_rx_src,
    input wire logic maint_bit56_rx_src,
    input wire logic [NUM_IRQ-1:0] u_irq_mask,
    input wire logic status_rd,
    output logic [NUM_IRQ-1:0] u_irq_status_q,
    output logic irq_q,
    output logic [1:0] maint_mode_q,
    output logic test_active_q,
    output logic u_goto_reset_q,
    output logic u_goto_transparent_q
);
    localparam int IW = $clog2(IDLE_LEN + 1);
    localparam logic [IW-1:0] IDLE_LAST = IW'(IDLE_LEN - 1);
    localparam logic [63:0] TEST_LAST = TEST_LEN - 64'h1;

    typedef struct packed {
        logic valid;
        maint_mode_t mode;
    } decode_t;

    // Sequence decode from half the edge count
    function automatic decode_t decode_count(input logic [EDGE_W-2:0] pulses);
        decode_t r;
        r.valid = 1'b1;
        r.mode = MODE_NORMAL;
        if (pulses == QUIET_PULSES) begin
            r.mode = MODE_QUIET;
        end else if (pulses == INS_LOSS_PULSES) begin
            r.mode = MODE_INS_LOSS;
        end else if (pulses != NORMAL_PULSES) begin
            r.valid = 1'b0;
        end
        return r;
    endfunction

    logic level;
    logic level_prev_q;
    logic [EDGE_W-1:0] edges_q;
    logic [IW-1:0] idle_q;
    logic eval;
    decode_t dec;
    logic [63:0] timer_q;
    logic expire;
    logic maint_event_q;
    maint_mode_t mode_q;
    logic [NUM_IRQ-1:0] events;

    pulse_filter #(
        .FILTER_LEN(FILTER_LEN)
    ) u_filter (
        .sys_clk(sys_clk),
        .rst(rst),
        .raw_in(maint_pulse_in),
        .level_q(level)
    );

    assign eval = (edges_q != '0) && (level == level_prev_q) && (idle_q == IDLE_LAST);
    assign dec = decode_count(edges_q[EDGE_W-1:1]);
    assign expire = test_active_q && (timer_q == TEST_LAST);

    // every level change counts, either polarity, until edges_q saturates at EDGE_MAX
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            level_prev_q <= 1'b0;
            edges_q <= '0;
        end else begin
            level_prev_q <= level;
            if (eval) begin
                edges_q <= '0;
            end else if (level != level_prev_q && edges_q != EDGE_MAX) begin
                edges_q <= edges_q + 1'b1;
            end
        end
    end

    // Idle gap counter, restarted by any edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            idle_q <= '0;
        end else if (level != level_prev_q || edges_q == '0 || eval) begin
            idle_q <= '0;
        end else begin
            idle_q <= idle_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer_q <= '0;
            test_active_q <= 1'b0;
        end else if (eval && dec.valid) begin
            // restart on a new valid sequence
            timer_q <= '0;
            test_active_q <= (dec.mode != MODE_NORMAL);
        end else if (expire) begin
            timer_q <= '0;
            test_active_q <= 1'b0;
        end else if (test_active_q) begin
            timer_q <= timer_q + 64'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode_q <= MODE_NORMAL;
        end else if (eval && dec.valid) begin
            mode_q <= dec.mode;
        end else if (expire) begin
            mode_q <= MODE_NORMAL;
        end
    end

    assign maint_mode_q = mode_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            u_goto_reset_q <= 1'b0;
            u_goto_transparent_q <= 1'b0;
        end else begin
            u_goto_reset_q <= (eval && dec.valid && dec.mode != MODE_INS_LOSS) ||
                (expire && !(eval && dec.valid));
            u_goto_transparent_q <= eval && dec.valid && dec.mode == MODE_INS_LOSS;
        end
    end

    // valid decode or expiry reports an event
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            maint_event_q <= 1'b0;
        end else begin
            maint_event_q <= (eval && dec.valid) || expire;
        end
    end

    always_comb begin
        events = '0;
        events[IRQ_MAINT] = maint_event_q;
        events[IRQ_CMD_IND] = u_cmd_ind_change_src;
        events[IRQ_EOC] = embedded_ops_rx_src;
        events[IRQ_M4] = maint_bit4_rx_src;
        events[IRQ_M56] = maint_bit56_rx_src;
    end

    u_irq_ctrl #(
        .N(NUM_IRQ)
    ) u_irq (
        .sys_clk(sys_clk),
        .rst(rst),
        .event_in(events),
        .u_irq_mask(u_irq_mask),
        .status_rd(status_rd),
        .u_irq_status_q(u_irq_status_q),
        .irq_q(irq_q)
    );
endmodule

// >>> rtl/maint_pkg.sv
package maint_pkg;

    // Clock and time base
    localparam int CLK_HZ = 100_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;

    // Input filter window, in ms
    localparam int FILTER_MS = 20;
    // Quiet time that closes a pulse sequence, in ms
    localparam int IDLE_MS = 150;
    // Test mode supervision time, in s
    localparam int TEST_S = 75;

    localparam int FILTER_CYCLES = FILTER_MS * CYC_PER_MS;
    localparam int IDLE_CYCLES = IDLE_MS * CYC_PER_MS;
    localparam logic [63:0] TEST_CYCLES = 64'(TEST_S) * 64'(CLK_HZ);

    // Pulse counts that select a mode
    localparam logic [3:0] QUIET_PULSES = 4'h6;
    localparam logic [3:0] INS_LOSS_PULSES = 4'h8;
    localparam logic [3:0] NORMAL_PULSES = 4'ha;

    // Edge counter width; saturates well above the largest valid count
    localparam int EDGE_W = 5;
    localparam logic [EDGE_W-1:0] EDGE_MAX = 5'h1f;

    // Interrupt source positions in the status word
    localparam int IRQ_MAINT = 0;
    localparam int IRQ_CMD_IND = 1;
    localparam int IRQ_EOC = 2;
    localparam int IRQ_M4 = 3;
    localparam int IRQ_M56 = 4;
    localparam int NUM_IRQ = 5;

    localparam logic [NUM_IRQ-1:0] IRQ_RESET = 5'h00;
    localparam logic [NUM_IRQ-1:0] MASK_RESET = 5'h00;

    // Maintenance mode indication, two bits
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_QUIET,
        MODE_INS_LOSS
    } maint_mode_t;

endpackage

// >>> rtl/pulse_filter.sv
`timescale 1ns/1ns
module pulse_filter
    import maint_pkg::*;
#(
    parameter int FILTER_LEN = FILTER_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic raw_in,
    output logic level_q
);
    localparam int CW = $clog2(FILTER_LEN + 1);
    localparam logic [CW-1:0] LAST = CW'(FILTER_LEN - 1);

    logic sync1_q;
    logic sync2_q;
    logic [CW-1:0] cnt_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_q <= '0;
            level_q <= 1'b0;
        end else if (sync2_q == level_q) begin
            cnt_q <= '0;
        end else if (cnt_q == LAST) begin
            cnt_q <= '0;
            level_q <= sync2_q;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule

// >>> rtl/u_irq_ctrl.sv
`timescale 1ns/1ns
module u_irq_ctrl
    import maint_pkg::*;
#(
    parameter int N = NUM_IRQ
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [N-1:0] event_in,
    input wire logic [N-1:0] u_irq_mask,
    input wire logic status_rd,
    output logic [N-1:0] u_irq_status_q,
    output logic irq_q
);
    // Events flagged before the request, and those collected after it
    logic [N-1:0] before_q;
    logic [N-1:0] after_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            before_q <= IRQ_RESET;
            after_q <= IRQ_RESET;
        end else if (status_rd) begin
            before_q <= after_q | event_in;
            after_q <= IRQ_RESET;
        end else if (irq_q) begin
            after_q <= after_q | event_in;
        end else begin
            before_q <= before_q | event_in;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            u_irq_status_q <= IRQ_RESET;
        end else if (status_rd) begin
            u_irq_status_q <= before_q & ~u_irq_mask;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else if (status_rd) begin
            irq_q <= 1'b0;
        end else if (!irq_q) begin
            irq_q <= |(before_q & ~u_irq_mask);
        end
    end
endmodule

// >>> verification/lmd_props.sv
`timescale 1ns/1ns
module lmd_props
    import maint_pkg::*;
#(
    parameter logic [63:0] TEST_LEN = TEST_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic maint_pulse_in,
    input wire logic u_cmd_ind_change_src,
    input wire logic embedded_ops_rx_src,
    input wire logic maint_bit4_rx_src,
    input wire logic maint_bit56_rx_src,
    input wire logic [NUM_IRQ-1:0] u_irq_mask,
    input wire logic status_rd,
    input wire logic [NUM_IRQ-1:0] u_irq_status_q,
    input wire logic irq_q,
    input wire logic [1:0] maint_mode_q,
    input wire logic test_active_q,
    input wire logic u_goto_reset_q,
    input wire logic u_goto_transparent_q
);
    logic [63:0] run_q;
    logic go;
    assign go = u_goto_reset_q || u_goto_transparent_q;
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Restarted by every forcing pulse, so it measures one test span
    always_ff @(posedge sys_clk) begin
        run_q <= (rst || !test_active_q || go) ? 64'h0 : run_q + 64'h1;
    end
    AST_GOTO_EXCL:
        assert property (!(u_goto_reset_q && u_goto_transparent_q)) else $error("both forces");
    AST_GOTO_ONE:
        assert property (go |=> !go) else $error("force pulse too long");
    AST_TRANSP:
        assert property (u_goto_transparent_q |-> maint_mode_q == 2'h2 && test_active_q)
            else $error("transparent without test");
    AST_QUIET:
        assert property (u_goto_reset_q && test_active_q |-> maint_mode_q == 2'h1)
            else $error("quiet mode wrong");
    AST_NORMAL:
        assert property (u_goto_reset_q && !test_active_q |-> maint_mode_q == 2'h0)
            else $error("normal mode wrong");
    AST_MODE_CAUSE:
        assert property ($changed(maint_mode_q) |-> go) else $error("mode moved alone");
    AST_MAINT_IRQ:
        assert property (go && !u_irq_mask[0] && !status_rd |-> ##[1:3] (irq_q || status_rd))
            else $error("no request after forcing");
    AST_READ_DROP:
        assert property (status_rd |=> !irq_q) else $error("request kept over read");
    AST_MASK_HIDE:
        assert property (status_rd |=> (u_irq_status_q & $past(u_irq_mask)) == 5'h00)
            else $error("masked bit shown");
    AST_STATUS_HOLD:
        assert property (!status_rd |=> $stable(u_irq_status_q)) else $error("status moved");
    AST_TEST_SPAN:
        assert property (run_q <= TEST_LEN) else $error("test mode too long");
endmodule
bind loop_maintenance_decoder lmd_props #(.TEST_LEN(TEST_LEN)) lmd_props_i (
    .sys_clk(sys_clk), .rst(rst), .maint_pulse_in(maint_pulse_in),
    .u_cmd_ind_change_src(u_cmd_ind_change_src), .embedded_ops_rx_src(embedded_ops_rx_src),
    .maint_bit4_rx_src(maint_bit4_rx_src), .maint_bit56_rx_src(maint_bit56_rx_src),
    .u_irq_mask(u_irq_mask), .status_rd(status_rd), .u_irq_status_q(u_irq_status_q),
    .irq_q(irq_q), .maint_mode_q(maint_mode_q), .test_active_q(test_active_q),
    .u_goto_reset_q(u_goto_reset_q), .u_goto_transparent_q(u_goto_transparent_q));

// >>> verification/loop_test_model.sv
`timescale 1ns/1ns
module loop_test_model (
    input wire logic sys_clk,
    output logic maint_pulse_in
);
    initial maint_pulse_in = 1'b0;
    // Odd edge count leaves the line inverted for later streams
    task automatic send(input int edges, input int half);
        repeat (edges) begin
            repeat (half) @(posedge sys_clk);
            maint_pulse_in <= ~maint_pulse_in;
        end
        repeat (60) @(posedge sys_clk);
    endtask
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    import maint_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] ev;
    logic [NUM_IRQ-1:0] u_irq_mask;
    logic status_rd;
    logic rd_seen = 1'b0;
    logic maint_pulse_in, irq_q, test_active_q, u_goto_reset_q, u_goto_transparent_q;
    logic [NUM_IRQ-1:0] u_irq_status_q;
    logic [1:0] maint_mode_q;
    logic [4:0] mode_exp[$];
    logic [4:0] stat_exp[$];
    int err_count = 0;
    int cmp_count = 0;
    int w;
    // Ignored counts, the last one drives the edge counter into saturation
    int bad_cnt[6] = '{1, 5, 7, 9, 11, 16};
    logic [4:0] stat_note;
    logic [4:0] mode_note;
    logic [4:0] mode_got;
    always #5 sys_clk = ~sys_clk;
    loop_test_model loop_test_model_i (.sys_clk(sys_clk), .maint_pulse_in(maint_pulse_in));
    loop_maintenance_decoder #(.FILTER_LEN(8), .IDLE_LEN(40), .TEST_LEN(64'h258))
        loop_maintenance_decoder_i (
        .sys_clk(sys_clk), .rst(rst), .maint_pulse_in(maint_pulse_in),
        .u_cmd_ind_change_src(ev[0]), .embedded_ops_rx_src(ev[1]),
        .maint_bit4_rx_src(ev[2]), .maint_bit56_rx_src(ev[3]), .u_irq_mask(u_irq_mask),
        .status_rd(status_rd), .u_irq_status_q(u_irq_status_q), .irq_q(irq_q),
        .maint_mode_q(maint_mode_q), .test_active_q(test_active_q),
        .u_goto_reset_q(u_goto_reset_q), .u_goto_transparent_q(u_goto_transparent_q));
    always @(posedge sys_clk) begin
        rd_seen <= status_rd;
        // Pop once, so a mismatch cannot skip a note
        if (rd_seen) begin
            stat_note = stat_exp.pop_front();
            `CHK(u_irq_status_q, stat_note)
        end
        if (u_goto_reset_q || u_goto_transparent_q) begin
            mode_got = {maint_mode_q, test_active_q, u_goto_reset_q, u_goto_transparent_q};
            mode_note = mode_exp.pop_front();
            `CHK(mode_got, mode_note)
        end
    end
    task automatic pulse(input int b);
        @(posedge sys_clk) ev[b] <= 1'b1;
        @(posedge sys_clk) ev[b] <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] exp);
        stat_exp.push_back(exp);
        @(posedge sys_clk) status_rd <= 1'b1;
        @(posedge sys_clk) status_rd <= 1'b0;
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        repeat (2) @(posedge sys_clk);
        while (irq_q !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        `CHK(irq_q, 1'b1)
    endtask
    task automatic end_of_test();
        $display("compares=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        end_of_test();
    end
    initial begin
        ev <= 4'h0;
        u_irq_mask <= 5'h00;
        status_rd <= 1'b0;
        void'($urandom(84872));
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        u_irq_mask <= 5'h04;
        pulse(1);
        pulse(0);
        wait_irq();
        pulse(2);
        rd(5'h02);
        wait_irq();
        rd(5'h08);
        u_irq_mask <= 5'h10;
        pulse(3);
        repeat (6) @(posedge sys_clk);
        `CHK(irq_q, 1'b0)
        pulse(0);
        wait_irq();
        pulse(3);
        rd(5'h02);
        repeat (6) @(posedge sys_clk);
        `CHK(irq_q, 1'b0)
        u_irq_mask <= 5'h00;
        wait_irq();
        rd(5'h10);
        $display("interrupt test done");
        w = 10 + int'($urandom % 4);
        loop_test_model_i.send(1, w);
        mode_exp.push_back(5'b01110);
        loop_test_model_i.send(12, w);
        `CHK(maint_mode_q, 2'h1)
        mode_exp.push_back(5'b10101);
        loop_test_model_i.send(16, w);
        `CHK(maint_mode_q, 2'h2)
        mode_exp.push_back(5'b00010);
        repeat (400) @(posedge sys_clk);
        `CHK(test_active_q, 1'b1)
        repeat (300) @(posedge sys_clk);
        `CHK(maint_mode_q, 2'h0)
        $display("inverse polarity and expiry test done");
        loop_test_model_i.send(1, w);
        mode_exp.push_back(5'b01110);
        loop_test_model_i.send(12, w);
        `CHK(test_active_q, 1'b1)
        mode_exp.push_back(5'b00010);
        loop_test_model_i.send(20, w);
        `CHK(test_active_q, 1'b0)
        // Edges closer than the filter window must never count
        loop_test_model_i.send(12, 3);
        `CHK(maint_mode_q, 2'h0)
        // Two plus four pulses would read as quiet if the count leaked
        loop_test_model_i.send(4, w);
        loop_test_model_i.send(8, w);
        `CHK(maint_mode_q, 2'h0)
        foreach (bad_cnt[i])
            loop_test_model_i.send(2 * bad_cnt[i], w);
        `CHK(mode_exp.size(), 0)
        `CHK(maint_mode_q, 2'h0)
        $display("maintenance count test done");
        end_of_test();
    end
endmodule
